// ---- hw/uart_shadow_pkg.sv ----
// constants, register map and carrier types for the shadow buffer uart
// assumes one 10 MHz clock and an apb slave with 32-bit data
package uart_shadow_pkg;

  // clock and serial timing
  localparam int CLK_HZ = 10_000_000;
  localparam int BAUD_RATE = 115_200;
  localparam int BIT_CYCLES = CLK_HZ / BAUD_RATE;
  localparam int HALF_BIT_CYCLES = BIT_CYCLES / 2;
  localparam int BAUD_CNT_W = 8;
  localparam int DATA_BITS = 8;

  // fifo geometry
  localparam int FIFO_DEPTH = 16;
  localparam int PTR_W = 4;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] FIFO_FULL_COUNT = CNT_W'(FIFO_DEPTH);

  // register map, byte addresses
  localparam logic [31:0] ALIAS_BASE_ADDR = 32'h5000_1130;
  localparam logic [31:0] ALIAS_14_ADDR = 32'h5000_1168;
  localparam logic [31:0] ALIAS_15_ADDR = 32'h5000_116c;
  localparam logic [31:0] CTRL_ADDR = 32'h5000_1200;
  localparam logic [31:0] LINE_STATUS_ADDR = 32'h5000_1204;
  localparam logic [31:0] LEVEL_ADDR = 32'h5000_1208;

  // reset values
  localparam logic [31:0] ALIAS_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  typedef struct packed {
    logic [29:0] zero;
    logic ir_mode;
    logic fifo_en;
  } fifo_control_t;

  typedef struct packed {
    logic [24:0] zero_hi;
    logic tx_idle;
    logic tx_holding_empty;
    logic [2:0] zero_lo;
    logic overrun;
    logic rx_data_ready;
  } line_status_t;

  typedef struct packed {
    logic [18:0] zero_hi;
    logic [CNT_W-1:0] rx_level;
    logic [2:0] zero_lo;
    logic [CNT_W-1:0] tx_level;
  } level_t;

  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } apb_req_t;

  typedef enum logic [1:0] {TX_IDLE, TX_LOAD, TX_SHIFT} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

endpackage : uart_shadow_pkg

// ---- hw/byte_fifo_ram.sv ----
// byte storage for one fifo, one write and one registered read port
// assumes pointers are kept by the instantiating fifo logic
`timescale 1ns/1ps
module byte_fifo_ram import uart_shadow_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wr_en,
  input wire logic [PTR_W-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [PTR_W-1:0] rd_addr,
  output logic [7:0] rd_data
);

  logic [7:0] mem [FIFO_DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read data lags the address by one cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : byte_fifo_ram

// ---- hw/uart_shadow_buffer_access.sv ----
// uart data path behind the sixteen shadow receive/transmit alias words
// assumes an apb master on SYS_CLK; SIN and SIR_IN are asynchronous pins
//
// The APB slave port was decided locally.
`timescale 1ns/1ps

module uart_shadow_buffer_access import uart_shadow_pkg::*; (
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SIN,
  input wire logic SIR_IN,
  output logic SOUT,
  output logic SIR_OUT_N
);

  apb_req_t req;
  logic pready_reg;
  logic [1:0] sin_sync_reg;
  logic [1:0] sir_sync_reg;
  logic rx_prev_reg;
  fifo_control_t ctrl_reg;
  logic overrun_reg;
  // receive side
  logic [PTR_W-1:0] rx_wr_ptr_reg;
  logic [PTR_W-1:0] rx_rd_ptr_reg;
  logic [CNT_W-1:0] rx_count_reg;
  logic [7:0] rx_hold_reg;
  logic rx_hold_valid_reg;
  logic [7:0] rx_ram_data;
  rx_state_t rx_state_reg;
  logic [BAUD_CNT_W-1:0] rx_baud_reg;
  logic [3:0] rx_bit_reg;
  logic [7:0] rx_shift_reg;
  // transmit side
  logic [PTR_W-1:0] tx_wr_ptr_reg;
  logic [PTR_W-1:0] tx_rd_ptr_reg;
  logic [CNT_W-1:0] tx_count_reg;
  logic [7:0] thr_reg;
  logic thr_full_reg;
  logic [7:0] tx_ram_data;
  tx_state_t tx_state_reg;
  logic [BAUD_CNT_W-1:0] tx_baud_reg;
  logic [3:0] tx_bit_reg;
  logic [9:0] tx_frame_reg;

  assign req = '{sel: PSEL, enable: PENABLE, write: PWRITE, addr: PADDR, wdata: PWDATA};

  // apb decode
  wire setup = req.sel && !req.enable && !pready_reg;
  wire alias_hit = (req.addr >= ALIAS_BASE_ADDR) && (req.addr <= ALIAS_15_ADDR)
                   && (req.addr[1:0] == 2'b00);
  wire ctrl_hit = req.addr == CTRL_ADDR;
  wire stat_hit = req.addr == LINE_STATUS_ADDR;
  wire level_hit = req.addr == LEVEL_ADDR;
  wire mapped = alias_hit || ctrl_hit || stat_hit || level_hit;
  wire wr_alias = setup && req.write && alias_hit;
  wire rd_alias = setup && !req.write && alias_hit;
  wire wr_ctrl = setup && req.write && ctrl_hit;
  wire rd_stat = setup && !req.write && stat_hit;

  wire fifo_en = ctrl_reg.fifo_en;
  wire fifo_flush = wr_ctrl && (req.wdata[0] != ctrl_reg.fifo_en);

  // pin synchronisers and receive line selection
  wire rx_line = ctrl_reg.ir_mode ? ~sir_sync_reg[1] : sin_sync_reg[1];

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      sin_sync_reg <= 2'b11;
      sir_sync_reg <= 2'b00;
      rx_prev_reg <= 1'b1;
    end else begin
      sin_sync_reg <= {sin_sync_reg[0], SIN};
      sir_sync_reg <= {sir_sync_reg[0], SIR_IN};
      rx_prev_reg <= rx_line;
    end
  end

  // receiver
  wire rx_bit_end = rx_baud_reg == BAUD_CNT_W'(BIT_CYCLES - 1);
  wire rx_half_end = rx_baud_reg == BAUD_CNT_W'(HALF_BIT_CYCLES - 1);
  wire rx_done = (rx_state_reg == RX_STOP) && rx_bit_end && rx_line;
  wire rx_full = rx_count_reg == FIFO_FULL_COUNT;
  wire rx_push = rx_done && fifo_en && !rx_full && !fifo_flush;
  wire rx_pop = rd_alias && fifo_en && (rx_count_reg != '0);
  wire overrun_event = rx_done && (fifo_en ? rx_full
                                           : (rx_hold_valid_reg && !rd_alias));
  wire rx_data_ready = fifo_en ? (rx_count_reg != '0) : rx_hold_valid_reg;
  wire [CNT_W-1:0] rx_count_next = fifo_flush ? '0
                                   : rx_count_reg + CNT_W'(rx_push) - CNT_W'(rx_pop);

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      rx_state_reg <= RX_IDLE;
      rx_baud_reg <= '0;
      rx_bit_reg <= '0;
      rx_shift_reg <= 8'h00;
    end else begin
      rx_baud_reg <= rx_baud_reg + BAUD_CNT_W'(1);
      case (rx_state_reg)
        RX_IDLE: begin
          rx_baud_reg <= '0;
          if (rx_prev_reg && !rx_line) begin
            rx_state_reg <= RX_START;
          end
        end
        RX_START: begin
          if (rx_half_end) begin
            rx_baud_reg <= '0;
            rx_bit_reg <= '0;
            rx_state_reg <= rx_line ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_bit_end) begin
            rx_baud_reg <= '0;
            rx_shift_reg <= {rx_line, rx_shift_reg[7:1]};
            rx_bit_reg <= rx_bit_reg + 4'h1;
            if (rx_bit_reg == 4'(DATA_BITS - 1)) begin
              rx_state_reg <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_bit_end) begin
            rx_state_reg <= RX_IDLE;
          end
        end
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      rx_wr_ptr_reg <= '0;
      rx_rd_ptr_reg <= '0;
      rx_count_reg <= '0;
      rx_hold_reg <= 8'h00;
      rx_hold_valid_reg <= 1'b0;
      overrun_reg <= 1'b0;
    end else begin
      rx_count_reg <= rx_count_next;
      rx_wr_ptr_reg <= fifo_flush ? '0 : rx_wr_ptr_reg + PTR_W'(rx_push);
      rx_rd_ptr_reg <= fifo_flush ? '0 : rx_rd_ptr_reg + PTR_W'(rx_pop);
      if (rx_done && !fifo_en) begin
        rx_hold_reg <= rx_shift_reg;
      end
      // arrival wins over a read in the same cycle
      if (rx_done && !fifo_en) begin
        rx_hold_valid_reg <= 1'b1;
      end else if (rd_alias || fifo_flush) begin
        rx_hold_valid_reg <= 1'b0;
      end
      if (overrun_event) begin
        overrun_reg <= 1'b1;
      end else if (rd_stat) begin
        overrun_reg <= 1'b0;
      end
    end
  end

  byte_fifo_ram rx_ram (
    .clk(SYS_CLK),
    .rstn(RSTN),
    .wr_en(rx_push),
    .wr_addr(rx_wr_ptr_reg),
    .wr_data(rx_shift_reg),
    .rd_addr(rx_rd_ptr_reg),
    .rd_data(rx_ram_data)
  );

  // transmit queue
  wire tx_full = tx_count_reg == FIFO_FULL_COUNT;
  wire tx_push = wr_alias && fifo_en && !tx_full && !fifo_flush;
  wire tx_load = tx_state_reg == TX_LOAD;
  wire tx_pop = tx_load && fifo_en && (tx_count_reg != '0);
  wire tx_holding_empty = fifo_en ? (tx_count_reg == '0) : !thr_full_reg;
  wire tx_pending = fifo_en ? (tx_count_reg != '0) : thr_full_reg;
  wire tx_bit_end = tx_baud_reg == BAUD_CNT_W'(BIT_CYCLES - 1);
  wire tx_line = (tx_state_reg == TX_SHIFT) ? tx_frame_reg[0] : 1'b1;
  wire [7:0] tx_byte = fifo_en ? tx_ram_data : thr_reg;
  wire [CNT_W-1:0] tx_count_next = fifo_flush ? '0
                                   : tx_count_reg + CNT_W'(tx_push) - CNT_W'(tx_pop);

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      tx_wr_ptr_reg <= '0;
      tx_rd_ptr_reg <= '0;
      tx_count_reg <= '0;
      thr_reg <= 8'h00;
      thr_full_reg <= 1'b0;
    end else begin
      tx_count_reg <= tx_count_next;
      tx_wr_ptr_reg <= fifo_flush ? '0 : tx_wr_ptr_reg + PTR_W'(tx_push);
      tx_rd_ptr_reg <= fifo_flush ? '0 : tx_rd_ptr_reg + PTR_W'(tx_pop);
      if (wr_alias && !fifo_en) begin
        thr_reg <= req.wdata[7:0];
      end
      // a write in the load cycle stays pending for the next frame
      if (wr_alias && !fifo_en) begin
        thr_full_reg <= 1'b1;
      end else if ((tx_load && !fifo_en) || fifo_flush) begin
        thr_full_reg <= 1'b0;
      end
    end
  end

  byte_fifo_ram tx_ram (
    .clk(SYS_CLK),
    .rstn(RSTN),
    .wr_en(tx_push),
    .wr_addr(tx_wr_ptr_reg),
    .wr_data(req.wdata[7:0]),
    .rd_addr(tx_rd_ptr_reg),
    .rd_data(tx_ram_data)
  );

  // transmitter, 8N1 frame, lsb first
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      tx_state_reg <= TX_IDLE;
      tx_baud_reg <= '0;
      tx_bit_reg <= '0;
      tx_frame_reg <= 10'h3ff;
    end else begin
      case (tx_state_reg)
        TX_IDLE: begin
          if (tx_pending && !fifo_flush) begin
            tx_state_reg <= TX_LOAD;
          end
        end
        TX_LOAD: begin
          tx_baud_reg <= '0;
          tx_bit_reg <= '0;
          tx_frame_reg <= {1'b1, tx_byte, 1'b0};
          tx_state_reg <= tx_pending ? TX_SHIFT : TX_IDLE;
        end
        TX_SHIFT: begin
          tx_baud_reg <= tx_baud_reg + BAUD_CNT_W'(1);
          if (tx_bit_end) begin
            tx_baud_reg <= '0;
            tx_frame_reg <= {1'b1, tx_frame_reg[9:1]};
            tx_bit_reg <= tx_bit_reg + 4'h1;
            if (tx_bit_reg == 4'(DATA_BITS + 1)) begin
              tx_state_reg <= TX_IDLE;
            end
          end
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  // serial outputs, infrared output carries tx_line uninverted and idles high
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      SOUT <= 1'b1;
      SIR_OUT_N <= 1'b1;
    end else begin
      SOUT <= ctrl_reg.ir_mode ? 1'b1 : tx_line;
      SIR_OUT_N <= ctrl_reg.ir_mode ? tx_line : 1'b1;
    end
  end

  // register read mux
  line_status_t status_word;
  level_t level_word;
  assign status_word = '{zero_hi: '0, tx_idle: (tx_state_reg == TX_IDLE) && !tx_pending,
                         tx_holding_empty: tx_holding_empty, zero_lo: '0,
                         overrun: overrun_reg, rx_data_ready: rx_data_ready};
  assign level_word = '{zero_hi: '0, rx_level: rx_count_reg, zero_lo: '0,
                        tx_level: tx_count_reg};
  wire [7:0] rx_byte = fifo_en ? ((rx_count_reg != '0) ? rx_ram_data : 8'h00)
                               : rx_hold_reg;
  wire [31:0] alias_word = {24'h00_0000, rx_byte};
  wire [31:0] prdata_next = alias_hit ? alias_word
                          : ctrl_hit ? 32'(ctrl_reg)
                          : stat_hit ? 32'(status_word)
                          : level_hit ? 32'(level_word)
                          : 32'h0000_0000;

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      ctrl_reg <= CTRL_RESET;
      pready_reg <= 1'b0;
      PRDATA <= ALIAS_RESET;
      PSLVERR <= 1'b0;
    end else begin
      pready_reg <= setup;
      if (setup) begin
        PRDATA <= req.write ? 32'h0000_0000 : prdata_next;
        PSLVERR <= !mapped;
      end else begin
        PSLVERR <= 1'b0;
      end
      if (wr_ctrl) begin
        ctrl_reg <= '{zero: '0, ir_mode: req.wdata[1], fifo_en: req.wdata[0]};
      end
    end
  end

  assign PREADY = pready_reg;

endmodule : uart_shadow_buffer_access

// ---- test/uart_shadow_asserts.sv ----
// assertions on the apb and serial pins of the shadow buffer uart
// assumes it is bound onto the top module's ports
`timescale 1ns/1ps
module uart_shadow_asserts import uart_shadow_pkg::*; (
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic SOUT,
  input wire logic SIR_OUT_N
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  logic [31:0] offs;
  logic alias_hit;
  logic mapped;
  assign offs = PADDR - ALIAS_BASE_ADDR;
  assign alias_hit = (offs < 32'h0000_0040) && (offs[1:0] == 2'b00);
  assign mapped = alias_hit || PADDR == CTRL_ADDR || PADDR == LINE_STATUS_ADDR
    || PADDR == LEVEL_ADDR;
  sequence setup_s;
    PSEL && !PENABLE;
  endsequence
  sequence answer_s;
    PSEL && PENABLE && PREADY;
  endsequence
  a_ready_after_setup: assert property (setup_s |=> answer_s)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (PREADY |=> !PREADY)
    else $error("ready held");
  a_err_with_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  a_unmapped_refused: assert property (
    setup_s ##0 !mapped |=> PSLVERR && PRDATA == 32'h0000_0000)
    else $error("unmapped not refused");
  a_alias_upper_zero: assert property (
    setup_s ##0 alias_hit |=> PRDATA[31:8] == 24'h00_0000)
    else $error("alias upper bits set");
  a_one_pin_only: assert property (SOUT || SIR_OUT_N)
    else $error("both outputs active");
  a_start_bit_held: assert property ($fell(SOUT) |-> (!SOUT) [*8])
    else $error("short bit on serial output");
  a_reset_idle: assert property (disable iff (1'b0)
    !RSTN |=> !PREADY && SOUT && SIR_OUT_N)
    else $error("outputs not idle in reset");
endmodule : uart_shadow_asserts

bind uart_shadow_buffer_access uart_shadow_asserts chk (.SYS_CLK(SYS_CLK), .RSTN(RSTN),
  .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .SOUT(SOUT), .SIR_OUT_N(SIR_OUT_N));

// ---- test/uart_far_end.sv ----
// far-end serial partner: sends frames, collects what the uart sends
// assumes 8n1 at BIT_CYCLES clocks per bit, lsb first
`timescale 1ns/1ps
module uart_far_end import uart_shadow_pkg::*; (
  input wire logic clk,
  input wire logic sout,
  input wire logic sir_out_n,
  output logic sin,
  output logic sir_in
);
  logic [8:0] rx_q[$];
  logic [7:0] b;
  logic ir;
  wire line = sout && sir_out_n;
  initial begin
    sin = 1'b1;
    sir_in = 1'b0;
  end
  // one frame on either pin, then gap idle clocks
  task automatic send(input logic [7:0] d, input logic irm, input int gap);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      if (irm) begin
        sir_in <= ~f[i];
      end else begin
        sin <= f[i];
      end
      repeat (BIT_CYCLES - 1) @(posedge clk);
    end
    repeat (gap) @(posedge clk);
  endtask : send
  // idle pin stays high, so the and of both is the active line
  always begin
    @(negedge line);
    ir = ~sir_out_n;
    repeat (HALF_BIT_CYCLES) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYCLES) @(posedge clk);
      b[i] = line;
    end
    repeat (BIT_CYCLES) @(posedge clk);
    rx_q.push_back({ir, b});
  end
endmodule : uart_far_end

// ---- test/uart_shadow_buffer_access_tb.sv ----
// self-checking bench: apb master plus far-end serial partner
// assumes the checker binds itself onto the design
`timescale 1ns/1ps
module uart_shadow_buffer_access_tb import uart_shadow_pkg::*;;
  typedef struct {
    logic [31:0] a;
    logic w;
    logic [31:0] e;
    logic err;
  } row_t;
  localparam logic [31:0] nil = 32'h0000_0000;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [31:0] padr = nil;
  logic [31:0] pwd = nil;
  logic [31:0] prd;
  logic pready;
  logic perr;
  logic sin;
  logic sir_in;
  logic sout;
  logic sir_n;
  logic [31:0] r;
  logic err;
  int n_fail = 0;
  int check_count = 0;
  row_t rows[8];
  uart_shadow_buffer_access dut (.SYS_CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd), .PRDATA(prd), .PREADY(pready),
    .PSLVERR(perr), .SIN(sin), .SIR_IN(sir_in), .SOUT(sout), .SIR_OUT_N(sir_n));
  uart_far_end far (.clk(clk), .sout(sout), .sir_out_n(sir_n), .sin(sin),
    .sir_in(sir_in));
  initial forever #50 clk = ~clk;
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up
  task automatic tick(inout int n, input int lim);
    n++;
    if (n > lim) begin
      n_fail++;
      wrap_up();
    end
    @(posedge clk);
  endtask : tick
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) tick(n, 20);
    r = prd;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : xfer
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input string nm);
    xfer(a, 1'b0, nil);
    chk(nm, e, r);
  endtask : rd
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask : wr
  task automatic wait_q(input int k);
    int n;
    n = 0;
    while (far.rx_q.size() < k) tick(n, 20000);
  endtask : wait_q
  task automatic rxb(input logic [8:0] e);
    chk("far byte", 32'(e), 32'(far.rx_q.pop_front()));
  endtask : rxb
  initial begin
    rows = '{'{ALIAS_14_ADDR, 1'b0, nil, 1'b0}, '{ALIAS_15_ADDR, 1'b0, nil, 1'b0},
      '{LINE_STATUS_ADDR, 1'b0, 32'h0000_0060, 1'b0}, '{LEVEL_ADDR, 1'b0, nil, 1'b0},
      '{CTRL_ADDR, 1'b1, nil, 1'b0}, '{CTRL_ADDR, 1'b0, nil, 1'b0},
      '{ALIAS_15_ADDR + 32'h0000_0004, 1'b0, nil, 1'b1},
      '{ALIAS_14_ADDR + 32'h0000_0001, 1'b0, nil, 1'b1}};
    repeat (5) @(posedge clk);
    chk("reset pins", 32'h0000_0003, 32'({pready, sout, sir_n}));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    $display("reset test done");
    foreach (rows[i]) begin
      xfer(rows[i].a, rows[i].w, nil);
      chk("row data", rows[i].e, r);
      chk("row error", 32'(rows[i].err), 32'(err));
    end
    $display("register rows done");
    far.send(8'h3c, 1'b0, 0);
    far.send(8'hc3, 1'b0, 400);
    rd(LINE_STATUS_ADDR, 32'h0000_0063, "status");
    rd(ALIAS_BASE_ADDR + 32'h0000_000c, 32'h0000_00c3, "rx byte");
    rd(LINE_STATUS_ADDR, 32'h0000_0060, "status");
    $display("overrun test done");
    wr(ALIAS_BASE_ADDR, 32'hffff_ffa5);
    wr(ALIAS_14_ADDR, 32'h0000_0011);
    wr(ALIAS_15_ADDR, 32'h0000_005a);
    rd(LINE_STATUS_ADDR, nil, "status");
    wait_q(2);
    rxb(9'h0a5);
    rxb(9'h05a);
    $display("holding test done");
    wr(CTRL_ADDR, 32'h0000_0001);
    for (int i = 0; i < 17; i++) far.send(8'h80 + 8'(i), 1'b0, 0);
    rd(LEVEL_ADDR, 32'h0000_1000, "rx level");
    rd(LINE_STATUS_ADDR, 32'h0000_0063, "status");
    for (int i = 0; i < 16; i++) begin
      rd(ALIAS_BASE_ADDR + 32'(4 * i), 32'h0000_0080 + 32'(i), "head");
    end
    rd(ALIAS_14_ADDR, nil, "empty fifo");
    rd(LEVEL_ADDR, nil, "drained level");
    $display("rx fifo test done");
    for (int i = 0; i < 20; i++) begin
      wr(ALIAS_BASE_ADDR + 32'(4 * (i % 16)), 32'h0000_0040 + 32'(i));
    end
    rd(LEVEL_ADDR, 32'h0000_0010, "tx level");
    wait_q(17);
    for (int i = 0; i < 17; i++) rxb(9'h040 + 9'(i));
    $display("tx fifo test done");
    wr(CTRL_ADDR, 32'h0000_0003);
    far.send(8'h96, 1'b1, 400);
    rd(ALIAS_14_ADDR, 32'h0000_0096, "ir byte");
    wr(ALIAS_15_ADDR, 32'h0000_0069);
    wait_q(1);
    rxb(9'h169);
    $display("infrared test done");
    // reset in mid-run with a byte queued for sending
    wr(ALIAS_14_ADDR, 32'h0000_0033);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    chk("mid reset pins", 32'h0000_0003, 32'({pready, sout, sir_n}));
    rstn <= 1'b1;
    rd(CTRL_ADDR, nil, "ctrl after reset");
    rd(LEVEL_ADDR, nil, "level after reset");
    rd(LINE_STATUS_ADDR, 32'h0000_0060, "status after reset");
    $display("mid-run reset test done");
    wrap_up();
  end
endmodule : uart_shadow_buffer_access_tb
